/* core/hsm_adc.sv */
`timescale 1ns/1ps
`include "hsm_cfg.svh"
module hsm_adc #(
    parameter int CONV_CYC = `HSM_CONV_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] sample,
    hsm_conv_if.adc cv
);
    logic [7:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [11:0] res_reg, res_next;
    initial begin
        if (CONV_CYC < 1 || CONV_CYC > 255) $error("CONV_CYC out of range");
    end
    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        res_next = res_reg;
        if (cv.start) begin
            busy_next = 1'b1;
            cnt_next = 8'(CONV_CYC - 1);
        end else if (busy_reg) begin
            if (cnt_reg == 8'h00) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                res_next = sample;
            end else begin
                cnt_next = cnt_reg - 8'h01;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            res_reg <= 12'h000;
        end else begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            res_reg <= res_next;
        end
    end
    assign cv.done = done_reg;
    assign cv.result = res_reg;
endmodule // hsm_adc

/* core/hsm_cfg.svh */
`ifndef HSM_CFG_SVH
`define HSM_CFG_SVH
`define HSM_ADDR_WR 8'h6a
`define HSM_ADDR_RD 8'h6b
`define HSM_FIELD_W 12
`define HSM_TEMP_W 10
`define HSM_BIAS_NS 1000
`define HSM_CLK_NS 100
`define HSM_BIAS_CYC ((`HSM_BIAS_NS + `HSM_CLK_NS - 1) / `HSM_CLK_NS)
`define HSM_CONV_CYC 8
`define HSM_CFG_RST 8'h80
`define HSM_CFG_TEMP_BIT 7
`define HSM_CFG_MODE_LSB 0
`define HSM_CFG_MODE_MSB 1
`define HSM_RES_BYTES 8
`endif

/* core/hsm_conv_if.sv */
`timescale 1ns/1ps
interface hsm_conv_if;
    logic start;
    hsm_pkg::hsm_chan_type chan;
    logic done;
    logic [11:0] result;
    modport seq (output start, output chan, input done, input result);
    modport adc (input start, input chan, output done, output result);
endinterface

/* core/hsm_pkg.sv */
package hsm_pkg;
    typedef enum logic [2:0] {
        HSM_IDLE = 3'b000,
        HSM_BIAS = 3'b001,
        HSM_CHECK = 3'b011,
        HSM_HALL = 3'b010,
        HSM_CONV = 3'b110,
        HSM_DONE = 3'b111
    } hsm_state_type;
    typedef enum logic [1:0] {
        HSM_CH_X = 2'b00,
        HSM_CH_Y = 2'b01,
        HSM_CH_Z = 2'b10,
        HSM_CH_T = 2'b11
    } hsm_chan_type;
endpackage

/* core/hsm_sequencer.sv */
`timescale 1ns/1ps
`include "hsm_cfg.svh"
// Summary of operation
// R01 - Bus master is the microcontroller; this block only answers as slave.
// R02 - After start-up idle in low power, accept configuration writes.
// R03 - Each reconfiguration runs bias, supply check, Hall bias, conversions, return.
// R04 - X, Y, Z go one by one through one mux to one converter.
// R05 - Temperature after three fields, on after reset, skipped if disabled.
// R06 - Field results are 12 bits, temperature result 10 bits.
// R07 - Low supply halts the sequencer; restart from the start when good.
// R08 - A restart event mid-function abandons it and restarts from the start.
// R09 - Active-low open-drain interrupt signals a finished measurement cycle.
// R10 - Data line is open-drain: pull low or release only.
// R11 - Slave address byte 6A for write, 6B for read.
// R12 - Master may change rate and mode anytime; applied without reset.
// R13 - Master should read results on interrupt rather than poll.
// R14 - Master issues bus reset after power-up and after brownouts.
// R15 - No device drives data or clock low during power-up.
// R16 - Results are readable no later than the interrupt asserts.
module hsm_sequencer #(
    parameter int BIAS_CYC = `HSM_BIAS_CYC,
    parameter int CONV_CYC = `HSM_CONV_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic int_n_out,
    output logic int_n_oe,
    input wire logic supply_ok,
    input wire logic [11:0] adc_sample,
    output logic [1:0] mux_sel,
    output logic hall_bias_en,
    output logic bias_en,
    output logic fast_osc_en,
    output logic [1:0] power_mode
);
    logic rst_s1_reg, rst_sync_n;
    hsm_conv_if cv ();
    initial begin
        if (BIAS_CYC < 1 || BIAS_CYC > 255) $error("BIAS_CYC out of range");
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end
    // R04 single shared converter
    hsm_adc #(.CONV_CYC(CONV_CYC)) u_adc (
        .clk(clk_sys),
        .rst_n(rst_sync_n),
        .sample(adc_sample),
        .cv(cv)
    );
    // Slave bus side: start/stop detection and byte shifter
    logic scl_q_reg, sda_q_reg;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] ptr_reg, ptr_next;
    logic act_reg, act_next;
    logic rd_reg, rd_next;
    logic first_reg, first_next;
    logic ack_reg, ack_next;
    logic drv_reg, drv_next;
    logic [7:0] cfg_reg, cfg_next;
    logic cfg_wr_reg, cfg_wr_next;
    logic [7:0] res_mem [0:`HSM_RES_BYTES-1];
    function automatic logic [7:0] rd_byte(input logic [3:0] p);
        rd_byte = (p < 4'(`HSM_RES_BYTES)) ? res_mem[p[2:0]] : cfg_reg;
    endfunction
    logic [7:0] rd_cur;
    assign rd_cur = rd_byte(ptr_reg);
    wire start_c = scl_in && scl_q_reg && sda_q_reg && !sda_in;
    wire stop_c = scl_in && scl_q_reg && !sda_q_reg && sda_in;
    wire scl_rise = scl_in && !scl_q_reg;
    wire scl_fall = !scl_in && scl_q_reg;
    always_comb begin
        bit_next = bit_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        act_next = act_reg;
        rd_next = rd_reg;
        first_next = first_reg;
        ack_next = ack_reg;
        drv_next = drv_reg;
        cfg_next = cfg_reg;
        cfg_wr_next = 1'b0;
        // R01 respond only after master start
        if (start_c) begin
            act_next = 1'b1;
            first_next = 1'b1;
            bit_next = 4'h0;
            drv_next = 1'b0;
            ack_next = 1'b0;
        end else if (stop_c) begin
            act_next = 1'b0;
            drv_next = 1'b0;
        end else if (act_reg && scl_rise && !ack_reg) begin
            sh_next = {sh_reg[6:0], sda_in};
            bit_next = bit_reg + 4'h1;
        end else if (act_reg && scl_rise && rd_reg && !first_reg && sda_in) begin
            // Master refused the byte: let go of the line until next start
            act_next = 1'b0;
        end else if (act_reg && scl_fall) begin
            if (ack_reg) begin
                ack_next = 1'b0;
                bit_next = 4'h0;
                drv_next = rd_reg ? !rd_cur[7] : 1'b0;
                if (rd_reg) sh_next = rd_cur;
            end else if (bit_reg == 4'h8) begin
                ack_next = 1'b1;
                // R11 address match
                if (first_reg) begin
                    first_next = 1'b0;
                    if (sh_reg == `HSM_ADDR_WR || sh_reg == `HSM_ADDR_RD) begin
                        rd_next = sh_reg[0];
                        drv_next = 1'b1;
                        ptr_next = rd_next ? 4'h0 : ptr_reg;
                    end else begin
                        act_next = 1'b0;
                        ack_next = 1'b0;
                    end
                end else if (!rd_reg) begin
                    // R02 R12 configuration accepted anytime
                    cfg_next = sh_reg;
                    cfg_wr_next = 1'b1;
                    drv_next = 1'b1;
                end else begin
                    ptr_next = ptr_reg + 4'h1;
                    drv_next = 1'b0;
                end
            end else if (rd_reg && !first_reg) begin
                // Shifter moves on each rise, so the next bit sits in bit 7
                drv_next = !sh_reg[7];
            end else begin
                drv_next = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 4'h0;
            act_reg <= 1'b0;
            rd_reg <= 1'b0;
            first_reg <= 1'b0;
            ack_reg <= 1'b0;
            drv_reg <= 1'b0;
            cfg_reg <= `HSM_CFG_RST;
            cfg_wr_reg <= 1'b0;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            act_reg <= act_next;
            rd_reg <= rd_next;
            first_reg <= first_next;
            ack_reg <= ack_next;
            drv_reg <= drv_next;
            cfg_reg <= cfg_next;
            cfg_wr_reg <= cfg_wr_next;
        end
    end
    // R10 pull low or release
    assign sda_out = 1'b0;
    assign sda_oe = drv_reg;
    // Measurement sequencer
    hsm_pkg::hsm_state_type st_reg, st_next;
    hsm_pkg::hsm_chan_type ch_reg, ch_next;
    logic [7:0] tmr_reg, tmr_next;
    logic pend_reg, pend_next;
    logic irq_reg, irq_next;
    logic cstart_reg, cstart_next;
    logic [11:0] rx_reg, rx_next, ry_reg, ry_next, rz_reg, rz_next;
    logic [9:0] rt_reg, rt_next;
    logic [1:0] mode_reg, mode_next;
    logic hall_reg, hall_next, bias_reg, bias_next, osc_reg, osc_next;
    always_comb begin
        st_next = st_reg;
        ch_next = ch_reg;
        tmr_next = tmr_reg;
        pend_next = pend_reg | cfg_wr_reg;
        irq_next = 1'b0;
        cstart_next = 1'b0;
        rx_next = rx_reg;
        ry_next = ry_reg;
        rz_next = rz_reg;
        rt_next = rt_reg;
        // R12 mode applied without reset
        mode_next = cfg_reg[`HSM_CFG_MODE_MSB:`HSM_CFG_MODE_LSB];
        // R07 R08 supply loss restarts sequence
        if (!supply_ok && st_reg != hsm_pkg::HSM_IDLE) begin
            st_next = hsm_pkg::HSM_BIAS;
            tmr_next = 8'(BIAS_CYC - 1);
        end else begin
            case (st_reg)
                hsm_pkg::HSM_IDLE: begin
                    // R03 cycle after reconfiguration
                    if (pend_reg) begin
                        pend_next = cfg_wr_reg;
                        st_next = hsm_pkg::HSM_BIAS;
                        tmr_next = 8'(BIAS_CYC - 1);
                    end
                end
                hsm_pkg::HSM_BIAS: begin
                    if (tmr_reg == 8'h00) st_next = hsm_pkg::HSM_CHECK;
                    else tmr_next = tmr_reg - 8'h01;
                end
                hsm_pkg::HSM_CHECK: begin
                    st_next = hsm_pkg::HSM_HALL;
                    tmr_next = 8'(BIAS_CYC - 1);
                end
                hsm_pkg::HSM_HALL: begin
                    if (tmr_reg == 8'h00) begin
                        st_next = hsm_pkg::HSM_CONV;
                        ch_next = hsm_pkg::HSM_CH_X;
                        cstart_next = 1'b1;
                    end else begin
                        tmr_next = tmr_reg - 8'h01;
                    end
                end
                hsm_pkg::HSM_CONV: begin
                    // R04 R05 R06 sequential channels
                    if (cv.done) begin
                        cstart_next = 1'b1;
                        case (ch_reg)
                            hsm_pkg::HSM_CH_X: begin
                                rx_next = cv.result;
                                ch_next = hsm_pkg::HSM_CH_Y;
                            end
                            hsm_pkg::HSM_CH_Y: begin
                                ry_next = cv.result;
                                ch_next = hsm_pkg::HSM_CH_Z;
                            end
                            hsm_pkg::HSM_CH_Z: begin
                                rz_next = cv.result;
                                // Mux stays on Z when temperature is off
                                if (cfg_reg[`HSM_CFG_TEMP_BIT]) begin
                                    ch_next = hsm_pkg::HSM_CH_T;
                                end else begin
                                    cstart_next = 1'b0;
                                    st_next = hsm_pkg::HSM_DONE;
                                end
                            end
                            default: begin
                                rt_next = cv.result[11:2];
                                cstart_next = 1'b0;
                                st_next = hsm_pkg::HSM_DONE;
                            end
                        endcase
                    end
                end
                hsm_pkg::HSM_DONE: begin
                    // R09 R16 results stored before interrupt
                    irq_next = 1'b1;
                    st_next = hsm_pkg::HSM_IDLE;
                end
                default: st_next = hsm_pkg::HSM_IDLE;
            endcase
        end
        // Enables registered so top outputs come from flops
        hall_next = (st_next == hsm_pkg::HSM_HALL) || (st_next == hsm_pkg::HSM_CONV);
        bias_next = (st_next != hsm_pkg::HSM_IDLE);
        osc_next = (st_next != hsm_pkg::HSM_IDLE) && (st_next != hsm_pkg::HSM_BIAS);
    end
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_reg <= hsm_pkg::HSM_IDLE;
            ch_reg <= hsm_pkg::HSM_CH_X;
            tmr_reg <= 8'h00;
            pend_reg <= 1'b0;
            irq_reg <= 1'b0;
            cstart_reg <= 1'b0;
            rx_reg <= 12'h000;
            ry_reg <= 12'h000;
            rz_reg <= 12'h000;
            rt_reg <= 10'h000;
            mode_reg <= 2'h0;
            hall_reg <= 1'b0;
            bias_reg <= 1'b0;
            osc_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ch_reg <= ch_next;
            tmr_reg <= tmr_next;
            pend_reg <= pend_next;
            irq_reg <= irq_next;
            cstart_reg <= cstart_next;
            rx_reg <= rx_next;
            ry_reg <= ry_next;
            rz_reg <= rz_next;
            rt_reg <= rt_next;
            mode_reg <= mode_next;
            hall_reg <= hall_next;
            bias_reg <= bias_next;
            osc_reg <= osc_next;
        end
    end
    assign res_mem[0] = rx_reg[11:4];
    assign res_mem[1] = ry_reg[11:4];
    assign res_mem[2] = rz_reg[11:4];
    assign res_mem[3] = rt_reg[9:2];
    assign res_mem[4] = {rx_reg[3:0], ry_reg[3:0]};
    assign res_mem[5] = {rz_reg[3:0], rt_reg[1:0], 2'b00};
    assign res_mem[6] = {5'h00, st_reg};
    assign res_mem[7] = {6'h00, mode_reg};
    assign cv.start = cstart_reg;
    assign cv.chan = ch_reg;
    assign mux_sel = ch_reg;
    assign hall_bias_en = hall_reg;
    assign bias_en = bias_reg;
    assign fast_osc_en = osc_reg;
    assign power_mode = mode_reg;
    // R09 open-drain active-low pulse
    assign int_n_out = 1'b0;
    assign int_n_oe = irq_reg;
endmodule // hsm_sequencer

/* test/hsm_mcu_model.sv */
`timescale 1ns/1ps
module hsm_mcu_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic v, output logic r);
        scl_low <= 1'b1;
        @(posedge clk);
        sda_low <= !v;
        repeat (3) @(posedge clk);
        scl_low <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        r = sda;
        @(posedge clk);
    endtask
    task automatic start_cond;
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic stop_cond;
        scl_low <= 1'b1;
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
        scl_low <= 1'b0;
        repeat (4) @(posedge clk);
        sda_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic last, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            q[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule // hsm_mcu_model

/* test/hsm_sequencer_monitor.sv */
`timescale 1ns/1ps
module hsm_sequencer_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic int_n_out,
    input wire logic int_n_oe,
    input wire logic supply_ok,
    input wire logic [11:0] adc_sample,
    input wire logic [1:0] mux_sel,
    input wire logic hall_bias_en,
    input wire logic bias_en,
    input wire logic fast_osc_en,
    input wire logic [1:0] power_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_hall_on;
        $rose(hall_bias_en);
    endsequence
    sequence s_osc_checked;
        $past(fast_osc_en);
    endsequence
    property p_sda_drive;
        !sda_out;
    endproperty
    a_sda_drive: assert property (p_sda_drive)
        else $error("data pin driven high");
    property p_int_drive;
        !int_n_out;
    endproperty
    a_int_drive: assert property (p_int_drive)
        else $error("interrupt pin driven high");
    property p_int_pulse;
        int_n_oe |=> !int_n_oe;
    endproperty
    a_int_pulse: assert property (p_int_pulse)
        else $error("interrupt longer than one cycle");
    property p_sda_edge;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_sda_edge: assert property (p_sda_edge)
        else $error("data changed while clock high");
    property p_hall_order;
        s_hall_on |-> s_osc_checked;
    endproperty
    a_hall_order: assert property (p_hall_order)
        else $error("hall bias without oscillator check");
    property p_halt;
        !supply_ok [*5] |-> !hall_bias_en && !int_n_oe;
    endproperty
    a_halt: assert property (p_halt)
        else $error("sequencer running on low supply");
    property p_mux_order;
        $changed(mux_sel) && fast_osc_en |->
            (mux_sel == $past(mux_sel) + 2'd1) || (mux_sel == hsm_pkg::HSM_CH_X);
    endproperty
    a_mux_order: assert property (p_mux_order)
        else $error("channel order broken");
    property p_int_last;
        int_n_oe |-> (mux_sel == hsm_pkg::HSM_CH_Z) || (mux_sel == hsm_pkg::HSM_CH_T);
    endproperty
    a_int_last: assert property (p_int_last)
        else $error("interrupt before last channel");
endmodule // hsm_sequencer_monitor
bind hsm_sequencer hsm_sequencer_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .supply_ok(supply_ok),
    .adc_sample(adc_sample), .mux_sel(mux_sel), .hall_bias_en(hall_bias_en),
    .bias_en(bias_en), .fast_osc_en(fast_osc_en), .power_mode(power_mode));

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b1;
    logic [11:0] adc_sample = 12'h000;
    logic scl_low, sda_low, sda_out, sda_oe, int_n_out, int_n_oe;
    logic hall_bias_en, bias_en, fast_osc_en;
    logic [1:0] mux_sel, power_mode;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [11:0] codes [4] = '{12'h123, 12'h456, 12'h789, 12'habc};
    wire scl_in = !scl_low;
    wire sda_in = !(sda_low || sda_oe);
    always #50 clk_sys = ~clk_sys;
    // Longer bias so the supply test can hit the hall phase
    hsm_sequencer #(.BIAS_CYC(40)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(int_n_out),
        .int_n_oe(int_n_oe), .supply_ok(supply_ok), .adc_sample(adc_sample),
        .mux_sel(mux_sel), .hall_bias_en(hall_bias_en), .bias_en(bias_en),
        .fast_osc_en(fast_osc_en), .power_mode(power_mode));
    hsm_mcu_model mcu (.clk(clk_sys), .sda(sda_in), .scl_low(scl_low), .sda_low(sda_low));
    // Front end gives each channel its own code
    always @(posedge clk_sys) adc_sample <= codes[mux_sel];
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cfg_write(input logic [7:0] c);
        logic a;
        mcu.start_cond();
        mcu.send(8'h6a, a);
        check(a, 1);
        mcu.send(c, a);
        check(a, 1);
        mcu.stop_cond();
    endtask
    task automatic wait_int(output logic [1:0] last);
        int n;
        logic osc;
        n = 0;
        osc = 1'b0;
        while (int_n_oe !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            osc = osc | fast_osc_en;
            n++;
        end
        last = mux_sel;
        check(n < 2000, 1);
        check(osc, 1);
        @(posedge clk_sys);
    endtask
    task automatic t_idle;
        logic a;
        check({bias_en, fast_osc_en, hall_bias_en, int_n_oe, power_mode}, 0);
        mcu.start_cond();
        mcu.send(8'h00, a);
        check(a, 0);
        mcu.stop_cond();
        check(bias_en, 0);
    endtask
    task automatic t_cycle;
        logic a;
        logic [1:0] last;
        logic [7:0] q;
        logic [7:0] exp [6] = '{8'h12, 8'h45, 8'h78, 8'hab, 8'h36, 8'h9c};
        cfg_write(8'h81);
        wait_int(last);
        check(last, 3);
        check(power_mode, 1);
        mcu.start_cond();
        mcu.send(8'h6b, a);
        check(a, 1);
        for (int k = 0; k < 8; k++) begin
            mcu.recv(k == 7, q);
            if (k < 6) check(q, exp[k]);
        end
        mcu.stop_cond();
    endtask
    task automatic t_no_temp;
        logic [1:0] last;
        cfg_write(8'h02);
        wait_int(last);
        check(last, 2);
        check(power_mode, 2);
    endtask
    task automatic t_supply;
        int n;
        logic seen;
        logic [1:0] last;
        n = 0;
        seen = 1'b0;
        cfg_write(8'h80);
        while (hall_bias_en !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        check(n < 200, 1);
        @(posedge clk_sys);
        supply_ok <= 1'b0;
        for (int k = 0; k < 30; k++) begin
            @(negedge clk_sys);
            if (k > 5) seen = seen | hall_bias_en | int_n_oe;
        end
        check(seen, 0);
        @(posedge clk_sys);
        supply_ok <= 1'b1;
        wait_int(last);
        check(last, 3);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_idle();
        t_cycle();
        t_no_temp();
        t_supply();
        t_cycle();
        end_sim();
    end
endmodule // testbench
